// file: rtl/aux_control_status_regs.sv
// auxiliary control and status register bank with serial access
// What this block does
// - a two-bit clock-edge field selects the shape of the CMOS clock output edge.
// - the pin beside the clock carries good status or a general purpose output per a two-bit mode.
// - a three-bit antenna current setting in bits four to two sets the expected current.
// - sensed current four or more times below the setting flags connection failure in status bit 0.
// - sensed current twice the setting or more cuts the antenna supply to zero volts.
// - bits one to zero of the antenna register select the antenna supply voltage.
// - status bit 2 reads one while the detector is enabled and its input level cannot make the chosen voltage.
// - writing one to request bit 0 while idle starts one measurement and the bit clears itself at the end.
// - at completion the result goes to upper bits one to zero and the lower register, and holds.
// - bit two of the upper result register shows a measurement in progress.
// - status bit 6 is the good status combining the indicators picked in a selection register.
// - the supply voltage field chooses among 1.8 V, 2.4 V, 2.7 V and 3.0 V.
`timescale 1ns/1ps
module aux_control_status_regs
  import aux_regs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // serial register port
  input wire logic spi_clk_i,
  input wire logic spi_sel_n_i,
  input wire logic spi_data_i,
  output logic spi_data_o,
  output logic spi_data_oe_o,
  // clock output control and companion pin
  output logic [1:0] clk_edge_sel_o,
  output logic companion_o,
  // antenna detector
  input wire logic [7:0] ant_current_i,
  input wire logic ant_level_low_i,
  input wire logic batt_low_i,
  input wire logic ref_low_i,
  output logic [2:0] ant_current_sel_o,
  output logic [1:0] ant_volt_sel_o,
  output logic ant_supply_on_o,
  // temperature converter
  output logic temp_start_o,
  input wire logic temp_done_i,
  input wire logic [9:0] temp_value_i
);
  reg_access_if bus ();

  logic [7:0] companion_output_mode;
  logic [7:0] good_select;
  logic [7:0] block_power_enables;
  logic temp_req;
  logic temp_busy;
  logic [9:0] temp_result;
  logic [7:0] antenna_supply_config;
  logic [7:0] clock_edge_control;
  logic conn_fail;
  logic over_current;
  logic [2:0] ind_a;
  logic [2:0] ind_b;
  logic [2:0] ind_c;
  logic [2:0] ind_f;
  logic [7:0] system_status;
  logic [7:0] nominal;
  logic [9:0] sense_x4;
  logic [8:0] nominal_x2;
  logic det_on;
  logic good;

  serial_reg_port u_port (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .spi_clk_i(spi_clk_i),
    .spi_sel_n_i(spi_sel_n_i),
    .spi_data_i(spi_data_i),
    .spi_data_o(spi_data_o),
    .spi_data_oe_o(spi_data_oe_o),
    .bus(bus)
  );

  // writable registers; result and status offsets have no write path
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      companion_output_mode <= RST_COMPANION_MODE;
      good_select <= RST_GOOD_SELECT;
      block_power_enables <= RST_POWER_ENABLES;
      antenna_supply_config <= RST_ANT_CONFIG;
      clock_edge_control <= RST_CLK_EDGE;
    end else if (bus.wr_stb) begin
      case (bus.addr)
        OFS_COMPANION_MODE: companion_output_mode <= bus.wdata;
        OFS_GOOD_SELECT: good_select <= bus.wdata;
        OFS_POWER_ENABLES: block_power_enables <= bus.wdata;
        OFS_ANT_CONFIG: antenna_supply_config <= bus.wdata;
        OFS_CLK_EDGE: clock_edge_control <= bus.wdata;
        OFS_TEMP_HIGH, OFS_TEMP_LOW, OFS_SYS_STATUS: ;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      temp_req <= 1'b0;
      temp_busy <= 1'b0;
      temp_start_o <= 1'b0;
    end else begin
      temp_start_o <= 1'b0;
      if (temp_busy && temp_done_i) begin
        temp_req <= 1'b0;
        temp_busy <= 1'b0;
      end else if (!temp_busy && bus.wr_stb && bus.addr == OFS_TEMP_REQUEST &&
                   bus.wdata[TEMP_START_BIT]) begin
        // a request while busy is dropped, so at most one run per write
        temp_req <= 1'b1;
        temp_busy <= 1'b1;
        temp_start_o <= 1'b1;
      end
    end
  end

  // whole ten-bit result captured in one edge
  // held untouched until the next completion
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      temp_result <= 10'h000;
    end else if (temp_busy && temp_done_i) begin
      temp_result <= temp_value_i;
    end
  end

  // comparator levels arrive from analog, so filter them like pins
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ind_a <= 3'h0;
      ind_b <= 3'h0;
      ind_c <= 3'h0;
      ind_f <= 3'h0;
    end else begin
      ind_a <= {ref_low_i, batt_low_i, ant_level_low_i};
      ind_b <= ind_a;
      ind_c <= ind_b;
      // keep the last agreed level while the stages disagree
      ind_f <= (ind_f & (ind_b ^ ind_c)) | (ind_c & ~(ind_b ^ ind_c));
    end
  end

  // expected current grows with the setting code
  assign nominal = 8'((antenna_supply_config[4:2] + 3'h1) * ANT_CURRENT_STEP);
  assign sense_x4 = {ant_current_i, 2'b00};
  assign nominal_x2 = {nominal, 1'b0};
  assign det_on = block_power_enables[DET_ENABLE_BIT];
  // flags registered so the long compare never reaches a pin

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      conn_fail <= 1'b0;
      over_current <= 1'b0;
    end else begin
      conn_fail <= det_on && (sense_x4 <= {2'b00, nominal});
      over_current <= det_on && ({1'b0, ant_current_i} >= nominal_x2);
    end
  end

  // any selected fault drops the good status
  assign good = ~|({ind_f[2], ind_f[1], ind_f[0], 1'b0, conn_fail} & good_select[4:0]);

  always_comb begin
    system_status = 8'h00;
    system_status[ST_CONN_FAIL_BIT] = conn_fail;
    system_status[ST_LEVEL_LOW_BIT] = ind_f[0] & det_on;
    system_status[ST_BATT_LOW_BIT] = ind_f[1];
    system_status[ST_REF_LOW_BIT] = ind_f[2];
    system_status[ST_GOOD_BIT] = good;
  end

  // read mux; unmapped addresses read zero
  // result and status exist only on this read path
  always_comb begin
    case (bus.addr)
      OFS_COMPANION_MODE: bus.rdata = companion_output_mode;
      OFS_GOOD_SELECT: bus.rdata = good_select;
      OFS_POWER_ENABLES: bus.rdata = block_power_enables;
      OFS_TEMP_REQUEST: bus.rdata = {7'h00, temp_req};
      OFS_TEMP_HIGH: bus.rdata = {5'h00, temp_busy, temp_result[9:8]};
      OFS_TEMP_LOW: bus.rdata = temp_result[7:0];
      OFS_ANT_CONFIG: bus.rdata = antenna_supply_config;
      OFS_SYS_STATUS: bus.rdata = system_status;
      OFS_CLK_EDGE: bus.rdata = clock_edge_control;
      default: bus.rdata = 8'h00;
    endcase
  end

  assign clk_edge_sel_o = clock_edge_control[1:0];
  assign ant_current_sel_o = antenna_supply_config[4:2];
  // voltage code 0..3 = 1.8, 2.4, 2.7, 3.0 V
  assign ant_volt_sel_o = antenna_supply_config[1:0];
  assign ant_supply_on_o = det_on & ~over_current;

  // companion pin source
  // mode codes two and three are unused and hold the pin low
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      companion_o <= 1'b0;
    end else begin
      case (companion_output_mode[1:0])
        MODE_GOOD_STATUS: companion_o <= good;
        MODE_GPO: companion_o <= companion_output_mode[GPO_VALUE_BIT];
        default: companion_o <= 1'b0;
      endcase
    end
  end
endmodule : aux_control_status_regs

// file: rtl/aux_regs_pkg.sv
// constants for the auxiliary control and status register bank
package aux_regs_pkg;
  // register offsets (7-bit serial address)
  localparam logic [6:0] OFS_COMPANION_MODE = 7'h04;
  localparam logic [6:0] OFS_GOOD_SELECT = 7'h05;
  localparam logic [6:0] OFS_POWER_ENABLES = 7'h07;
  localparam logic [6:0] OFS_TEMP_REQUEST = 7'h0A;
  localparam logic [6:0] OFS_TEMP_HIGH = 7'h0B;
  localparam logic [6:0] OFS_TEMP_LOW = 7'h0C;
  localparam logic [6:0] OFS_ANT_CONFIG = 7'h0D;
  localparam logic [6:0] OFS_SYS_STATUS = 7'h0E;
  localparam logic [6:0] OFS_CLK_EDGE = 7'h3F;
  // field positions
  localparam int DET_ENABLE_BIT = 5;
  localparam int TEMP_START_BIT = 0;
  localparam int TEMP_BUSY_BIT = 2;
  localparam int ST_CONN_FAIL_BIT = 0;
  localparam int ST_LEVEL_LOW_BIT = 2;
  localparam int ST_BATT_LOW_BIT = 3;
  localparam int ST_REF_LOW_BIT = 4;
  localparam int ST_GOOD_BIT = 6;
  localparam int GPO_VALUE_BIT = 2;
  // reset values
  localparam logic [7:0] RST_COMPANION_MODE = 8'h00;
  localparam logic [7:0] RST_GOOD_SELECT = 8'h1D;
  localparam logic [7:0] RST_POWER_ENABLES = 8'hFF;
  localparam logic [7:0] RST_ANT_CONFIG = 8'h00;
  localparam logic [7:0] RST_CLK_EDGE = 8'h00;
  // companion pin modes
  localparam logic [1:0] MODE_GOOD_STATUS = 2'h0;
  localparam logic [1:0] MODE_GPO = 2'h1;
  // expected antenna current per setting step, in sense-code units
  localparam logic [7:0] ANT_CURRENT_STEP = 8'h10;
  // serial frame: one direction bit, seven address bits, eight data bits
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] ADDR_LAST_BIT = 5'h07;
endpackage : aux_regs_pkg

// file: rtl/reg_access_if.sv
// register access carrier between serial slave and register bank
`timescale 1ns/1ps
interface reg_access_if;
  logic wr_stb;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport slave (output wr_stb, output addr, output wdata, input rdata);
  modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface : reg_access_if

// file: rtl/serial_reg_port.sv
// three-wire serial slave turning frames into register accesses
`timescale 1ns/1ps
module serial_reg_port
  import aux_regs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // serial pins
  input wire logic spi_clk_i,
  input wire logic spi_sel_n_i,
  input wire logic spi_data_i,
  output logic spi_data_o,
  output logic spi_data_oe_o,
  // register side
  reg_access_if.slave bus
);
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] sync_c;
  logic [2:0] filt;
  logic clk_q;
  logic [4:0] cnt;
  logic is_read;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic rise;
  logic fall;
  logic active;

  // a pin change counts only once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          sync_a[gi] <= (gi == 1) ? 1'b1 : 1'b0;
          sync_b[gi] <= (gi == 1) ? 1'b1 : 1'b0;
          sync_c[gi] <= (gi == 1) ? 1'b1 : 1'b0;
          filt[gi] <= (gi == 1) ? 1'b1 : 1'b0;
        end else begin
          sync_a[gi] <= (gi == 0) ? spi_clk_i : ((gi == 1) ? spi_sel_n_i : spi_data_i);
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
          if (sync_b[gi] == sync_c[gi]) begin
            filt[gi] <= sync_c[gi];
          end
        end
      end
    end
  endgenerate

  assign active = ~filt[1];
  assign rise = filt[0] & ~clk_q;
  assign fall = ~filt[0] & clk_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= filt[0];
    end
  end

  // input side: sampled on rising serial clock
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt <= 5'h00;
      is_read <= 1'b0;
      bus.addr <= 7'h00;
      shift_in <= 8'h00;
      bus.wdata <= 8'h00;
      bus.wr_stb <= 1'b0;
    end else begin
      bus.wr_stb <= 1'b0;
      if (!active) begin
        cnt <= 5'h00;
      end else if (rise && cnt < FRAME_BITS) begin
        cnt <= cnt + 5'h01;
        if (cnt == 5'h00) begin
          is_read <= filt[2];
        end else if (cnt <= ADDR_LAST_BIT) begin
          bus.addr <= {bus.addr[5:0], filt[2]};
        end else begin
          shift_in <= {shift_in[6:0], filt[2]};
        end
        if (cnt == FRAME_BITS - 5'h01 && !is_read) begin
          bus.wdata <= {shift_in[6:0], filt[2]};
          bus.wr_stb <= 1'b1;
        end
      end
    end
  end

  // output side: read data shifted out on falling serial clock
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      spi_data_o <= 1'b0;
      spi_data_oe_o <= 1'b0;
      shift_out <= 8'h00;
    end else if (!active || !is_read || cnt == FRAME_BITS) begin
      if (fall || !active) begin
        spi_data_oe_o <= 1'b0;
      end
    end else if (fall && cnt == ADDR_LAST_BIT + 5'h01) begin
      // snapshot taken once, so a byte never tears mid-shift
      spi_data_oe_o <= 1'b1;
      spi_data_o <= bus.rdata[7];
      shift_out <= {bus.rdata[6:0], 1'b0};
    end else if (fall && cnt > ADDR_LAST_BIT + 5'h01) begin
      spi_data_o <= shift_out[7];
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end
endmodule : serial_reg_port

// file: verif/aux_regs_asserts.sv
// port assertions for the auxiliary register bank
`timescale 1ns/1ps
module aux_regs_asserts (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic spi_sel_n_i,
  input wire logic [1:0] clk_edge_sel_o,
  input wire logic [7:0] ant_current_i,
  input wire logic [2:0] ant_current_sel_o,
  input wire logic [1:0] ant_volt_sel_o,
  input wire logic ant_supply_on_o,
  input wire logic companion_o,
  input wire logic temp_start_o,
  input wire logic temp_done_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic busy;
  logic over_now;
  // twice the nominal (setting+1)*16 or more
  assign over_now = int'(ant_current_i) >= (int'(ant_current_sel_o) + 1) * 32;
  sequence s_over;
    $stable(ant_current_sel_o) && over_now;
  endsequence
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) busy <= 1'b0;
    else if (temp_start_o) busy <= 1'b1;
    else if (temp_done_i) busy <= 1'b0;
  end
  a_start_pulse: assert property (temp_start_o |=> !temp_start_o)
    else $error("start pulse longer than one cycle");
  a_one_start: assert property (busy |-> !temp_start_o)
    else $error("second start while busy");
  a_over_cut: assert property (s_over |=> !ant_supply_on_o)
    else $error("supply kept on at overcurrent");
  a_cut_cause: assert property ($fell(ant_supply_on_o) |-> $past(over_now) || !spi_sel_n_i)
    else $error("supply cut without cause");
  // settings move only while a frame is open
  a_edge_write: assert property ($changed(clk_edge_sel_o) |-> !spi_sel_n_i)
    else $error("clock edge field moved outside a write");
  a_cur_write: assert property ($changed(ant_current_sel_o) |-> !spi_sel_n_i)
    else $error("current setting moved outside a write");
  a_volt_write: assert property ($changed(ant_volt_sel_o) |-> !spi_sel_n_i)
    else $error("voltage code moved outside a write");
  a_reset_state: assert property ($fell(rst_i) |-> !temp_start_o && !companion_o &&
    ant_supply_on_o && clk_edge_sel_o == 2'h0) else $error("bad state after reset");
endmodule : aux_regs_asserts
bind aux_control_status_regs aux_regs_asserts aux_regs_asserts_i (.ref_clk_i, .rst_i,
  .spi_sel_n_i, .clk_edge_sel_o, .ant_current_i, .ant_current_sel_o, .ant_volt_sel_o,
  .ant_supply_on_o, .companion_o, .temp_start_o, .temp_done_i);

// file: verif/serial_host_model.sv
// host controller model for the three-wire serial port
`timescale 1ns/1ps
module serial_host_model (
  // clock
  input wire logic ref_clk_i,
  // serial pins
  output logic spi_clk_o,
  output logic spi_sel_n_o,
  output logic spi_pin_o,
  input wire logic spi_data_i,
  input wire logic spi_data_oe_i
);
  logic drive = 1'b1;
  logic bit_out = 1'b0;
  int half = 6;
  // released line drifts away from the last host value
  assign spi_pin_o = spi_data_oe_i ? spi_data_i : (drive ? bit_out : ~bit_out);
  initial begin
    spi_clk_o = 1'b0;
    spi_sel_n_o = 1'b1;
  end
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
    output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, d};
    q = 8'h00;
    spi_sel_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      drive = !(rd && i < 8);
      bit_out = f[i];
      repeat (half) @(negedge ref_clk_i);
      spi_clk_o = 1'b1;
      q[i % 8] = spi_pin_o;
      repeat (half) @(negedge ref_clk_i);
      spi_clk_o = 1'b0;
    end
    drive = 1'b1;
    repeat (half) @(negedge ref_clk_i);
    spi_sel_n_o = 1'b1;
    repeat (half) @(negedge ref_clk_i);
  endtask : xfer
endmodule : serial_host_model

// file: verif/aux_control_status_regs_tb_top.sv
// self-checking bench for the auxiliary register bank
`timescale 1ns/1ps
module aux_control_status_regs_tb_top;
  import aux_regs_pkg::*;
  typedef struct packed {
    logic [6:0] a;
    logic [7:0] d;
    logic [6:0] r;
    logic [7:0] c;
    logic [2:0] f;
    logic [7:0] e;
  } row_t;
  localparam logic [6:0] ST = OFS_SYS_STATUS;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sclk, sel_n, pin, dout, doe, comp, tstart, sup;
  logic tdone = 1'b0, lvl_low = 1'b0, batt_low = 1'b0, ref_low = 1'b0;
  logic [1:0] edge_sel, volt_sel;
  logic [2:0] cur_sel;
  logic [7:0] cur = 8'h60, q;
  logic [9:0] tval = 10'h2B5;
  int n_fail = 0, comparisons = 0, tcnt = 0, n_start = 0;
  row_t rows [13] = '{
    '{OFS_CLK_EDGE, 8'h03, OFS_CLK_EDGE, 8'h60, 3'h0, 8'h03},
    '{OFS_ANT_CONFIG, 8'h16, OFS_ANT_CONFIG, 8'h60, 3'h0, 8'h16},
    '{OFS_COMPANION_MODE, 8'h05, OFS_COMPANION_MODE, 8'h60, 3'h0, 8'h05},
    '{ST, 8'hFF, ST, 8'h60, 3'h0, 8'h40},
    '{7'h20, 8'hA5, 7'h20, 8'h60, 3'h0, 8'h00},
    '{OFS_TEMP_LOW, 8'h5A, OFS_TEMP_LOW, 8'h60, 3'h0, 8'h00},
    '{OFS_COMPANION_MODE, 8'h00, ST, 8'h18, 3'h0, 8'h01},
    '{ST, 8'hFF, ST, 8'h19, 3'h0, 8'h40},
    '{ST, 8'hFF, ST, 8'h60, 3'h4, 8'h04},
    '{ST, 8'hFF, ST, 8'h60, 3'h2, 8'h08},
    '{ST, 8'hFF, ST, 8'h60, 3'h1, 8'h10},
    '{OFS_GOOD_SELECT, 8'h0D, ST, 8'h60, 3'h1, 8'h50},
    '{OFS_GOOD_SELECT, 8'h1D, ST, 8'h60, 3'h1, 8'h10}};
  always #10 ref_clk_i = ~ref_clk_i;
  aux_control_status_regs aux_control_status_regs_i (.ref_clk_i, .rst_i, .spi_clk_i(sclk),
    .spi_sel_n_i(sel_n), .spi_data_i(pin), .spi_data_o(dout), .spi_data_oe_o(doe),
    .clk_edge_sel_o(edge_sel), .companion_o(comp), .ant_current_i(cur),
    .ant_level_low_i(lvl_low), .batt_low_i(batt_low), .ref_low_i(ref_low),
    .ant_current_sel_o(cur_sel), .ant_volt_sel_o(volt_sel), .ant_supply_on_o(sup),
    .temp_start_o(tstart), .temp_done_i(tdone), .temp_value_i(tval));
  serial_host_model serial_host_model_i (.ref_clk_i, .spi_clk_o(sclk), .spi_sel_n_o(sel_n),
    .spi_pin_o(pin), .spi_data_i(dout), .spi_data_oe_i(doe));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    serial_host_model_i.xfer(1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    serial_host_model_i.xfer(1'b1, a, 8'h00, q);
  endtask : rd
  task automatic settle();
    repeat (8) @(negedge ref_clk_i);
  endtask : settle
  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // slow converter, so busy can be read mid-measurement
  always @(negedge ref_clk_i) begin
    tdone <= (tstart !== 1'b1) && (tcnt == 1);
    if (tstart === 1'b1) begin
      n_start++;
      tcnt = 1500;
    end else if (tcnt > 0) begin
      tcnt--;
    end
  end
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (20) @(negedge ref_clk_i);
    check({edge_sel, volt_sel, cur_sel, sup}, 8'h01);
    check({6'h00, comp, tstart}, 8'h00);
    rst_i = 1'b0;
    settle();
    foreach (rows[k]) begin
      cur = rows[k].c;
      {lvl_low, batt_low, ref_low} = rows[k].f;
      wr(rows[k].a, rows[k].d);
      rd(rows[k].r);
      check(q, rows[k].e);
    end
    check({edge_sel, cur_sel, volt_sel, 1'b0}, 8'hEC);
    check({7'h00, comp}, 8'h00);
    ref_low = 1'b0;
    settle();
    check({7'h00, comp}, 8'h01);
    wr(OFS_COMPANION_MODE, 8'h05);
    check({7'h00, comp}, 8'h01);
    wr(OFS_COMPANION_MODE, 8'h06);
    check({7'h00, comp}, 8'h00);
    wr(OFS_COMPANION_MODE, 8'h01);
    check({7'h00, comp}, 8'h00);
    cur = 8'hC0;
    settle();
    check({7'h00, sup}, 8'h00);
    cur = 8'hBF;
    settle();
    check({7'h00, sup}, 8'h01);
    lvl_low = 1'b1;
    // detector switched off by the host
    wr(OFS_POWER_ENABLES, 8'hDF);
    rd(ST);
    check({q[7:1], sup}, 8'h00);
    lvl_low = 1'b0;
    wr(OFS_POWER_ENABLES, 8'hFF);
    wr(OFS_TEMP_REQUEST, 8'h01);
    serial_host_model_i.half = 10;
    rd(OFS_TEMP_REQUEST);
    check(q, 8'h01);
    rd(OFS_TEMP_HIGH);
    check(q, 8'h04);
    wr(OFS_TEMP_REQUEST, 8'h01);
    serial_host_model_i.half = 6;
    for (int w = 0; w < 3000 && tcnt != 0; w++)
      @(negedge ref_clk_i);
    if (tcnt != 0) begin
      n_fail++;
    end else begin
      check(8'(n_start), 8'h01);
      rd(OFS_TEMP_HIGH);
      check(q, 8'h02);
      rd(OFS_TEMP_LOW);
      check(q, 8'hB5);
      rd(OFS_TEMP_REQUEST);
      check(q, 8'h00);
    end
    complete_run();
  end
endmodule : aux_control_status_regs_tb_top
